/* hbh_host_model.sv */
// Purpose: external host that borrows the local-memory bus
// Assumes: bench raises want to ask for the bus, drops it to give it back
// Notes:   request moves just after the rising edge, like a real master
`timescale 1ns/100ps
`default_nettype none
`include "hbh_map.svh"
module hbh_host_model
  import hbh_pkg::*;
(
  input  wire logic                  sys_clk,            // shared clock
  input  wire logic                  want,               // bench asks for the bus
  input  wire logic [`HBH_PRI_W-1:0] pri,                // pending cycle code
  output var  logic                  host_bus_request_n  // request pin, low
);
  // request follows want; an urgent code hands the bus back early
  initial begin
    host_bus_request_n = 1'b1;
  end
  always @(posedge sys_clk) begin
    if (want && pri != 2'h3) begin
      host_bus_request_n <= 1'b0;
    end else begin
      host_bus_request_n <= 1'b1;
    end
  end
endmodule : hbh_host_model
`default_nettype wire

/* hbh_map.svh */
// Purpose: constants for the host bus handover and reset control block
// Assumes: one 125 MHz clock, synchronous active-low reset
// Notes:   included by the package and top design files; the pin filter and interface do not include it
// Summary of operation
// RULE1: host request floats bus, then acknowledge low
// RULE2: request gone: acknowledge high, then drive bus
// RULE3: host pulls request low to take bus
// RULE4: host request synchronised before use
// RULE5: request low at reset release: processor runs
// RULE6: request high at release: halt until third edge
// RULE7: output two-bit highest pending cycle priority
// RULE8: host may watch priority to return bus
// RULE9: all logic runs on the input clock
// RULE10: outputs change only with output clock; here only priority, packet outputs and the ack fall do
// RULE11: three rising-edge interrupt inputs
// RULE12: first edge interrupt highest, then second, third
// RULE13: halted start: third edge unhalts, no pending flag
// RULE14: active-low level interrupt, lowest priority
// RULE15: level source holds low until recognised
// RULE16: in reset registers initialise, outputs inactive; here the pin filter stages are not reset and keep tracking the pins
// RULE17: byte order latched from strap at release
// RULE18: three-line external packet transfer request input
// RULE19: acknowledge low: bus floats, no cycle starts
`ifndef HBH_MAP_SVH
`define HBH_MAP_SVH
`define HBH_IRQ_NONE    3'h0
`define HBH_IRQ_FIRST   3'h1
`define HBH_IRQ_SECOND  3'h2
`define HBH_IRQ_THIRD   3'h3
`define HBH_IRQ_LEVEL   3'h4
`define HBH_PRI_W       2
`define HBH_XPT_W       3
`define HBH_VEC_W       3
`define HBH_FLT_SETTLE  2'h2
`endif

/* hbh_pin_sync.sv */
// Purpose: three-stage pin synchroniser, a change counts when stages two and three agree
// Assumes: all inputs asynchronous to sys_clk
// Notes:   stage one is read only by stage two, never by logic
`timescale 1ns/100ps
`default_nettype none
module hbh_pin_sync
  import hbh_pkg::*;
(
  input  wire logic       sys_clk,   // system clock
  input  wire logic       rst_n,     // sync reset, active low
  input  wire logic [8:0] pins,      // raw pin levels
  hbh_sync_if.src         so         // filtered levels
);
  logic [8:0] s1_q, s1_d;  // metastability stage
  logic [8:0] s2_q, s2_d;  // second stage
  logic [8:0] s3_q, s3_d;  // third stage
  logic [8:0] f_q,  f_d;   // accepted level
  // rst_n is deliberately not used: the stages must keep tracking the pins
  // during reset, so that the request and strap levels are valid at release

  // agreement of stages two and three updates the accepted level
  always_comb begin
    s1_d = pins;
    s2_d = s1_q;
    s3_d = s2_q;
    f_d  = f_q;
    for (int i = 0; i < 9; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        f_d[i] = s3_q[i];
      end
    end
  end

  // registers only; no reset so pin levels settle while reset is held
  always_ff @(posedge sys_clk) begin
    s1_q <= s1_d;
    s2_q <= s2_d;
    s3_q <= s3_d;
    f_q  <= f_d;
  end

  assign so.req_n  = f_q[0];  // RULE4
  assign so.eirq   = f_q[3:1];
  assign so.xpt    = f_q[6:4];
  assign so.strap  = f_q[7];
  assign so.lirq_n = f_q[8];
endmodule : hbh_pin_sync
`default_nettype wire

/* hbh_pkg.sv */
// Purpose: shared types of the host bus handover block
// Assumes: hbh_map.svh holds the numbers
// Notes:   types only
`include "hbh_map.svh"
package hbh_pkg;
  typedef enum logic [1:0] {HBH_OWN, HBH_FLOAT, HBH_GRANTED, HBH_RETURN} hbh_bus_t;
  typedef logic [`HBH_PRI_W-1:0] hbh_pri_t;
endpackage : hbh_pkg

/* hbh_sync_if.sv */
// Purpose: carries synchronised pin levels from the filter to the top
// Assumes: one clock domain
// Notes:   filter drives, top reads
`timescale 1ns/100ps
`default_nettype none
interface hbh_sync_if;
  logic       req_n;   // host request, filtered
  logic [2:0] eirq;    // edge interrupts, filtered
  logic       lirq_n;  // level interrupt, filtered
  logic [2:0] xpt;     // packet request, filtered
  logic       strap;   // byte-order strap, filtered
  modport src (output req_n, eirq, lirq_n, xpt, strap);
  modport dst (input  req_n, eirq, lirq_n, xpt, strap);
endinterface : hbh_sync_if
`default_nettype wire

/* hbh_top.sv */
// Purpose: host bus handover, reset strap capture and interrupt intake
// Assumes: sys_clk is the input clock; priority, packet outputs and the ack fall step with local_output_clock
// Notes:   bus outputs are represented by a drive enable toward the pad ring
`timescale 1ns/100ps
`default_nettype none
`include "hbh_map.svh"
module hbh_top
  import hbh_pkg::*;
(
  input  wire logic                  sys_clk,                 // input clock
  input  wire logic                  rst_n,                   // sync reset, active low
  input  wire logic                  host_bus_request_n,      // host wants bus, low
  input  wire logic                  edge_irq_first,          // rising-edge irq, top
  input  wire logic                  edge_irq_second,         // rising-edge irq
  input  wire logic                  edge_irq_third_unhalt,   // rising-edge irq and unhalt
  input  wire logic                  level_irq_n,             // level irq, low
  input  wire logic                  user_timing_strap,       // byte-order strap
  input  wire logic [`HBH_XPT_W-1:0] external_packet_request, // packet request code
  input  wire logic [3:0]            cycle_req,               // pending cycle requests, bit 3 top
  input  wire logic                  irq_ack,                 // processor took irq_vector
  output logic                       local_output_clock,      // output clock, half rate
  output logic                       host_grant_ack_n,        // bus released, low
  output logic                       bus_drive_en,            // local-memory bus driven
  output logic                       cycle_start_en,          // memory cycles may start
  output logic [`HBH_PRI_W-1:0]      pending_cycle_priority,  // top pending cycle code
  output logic                       master_run,              // processor running
  output logic                       big_endian,              // byte order mode
  output logic [`HBH_VEC_W-1:0]      irq_vector,              // top pending interrupt
  output logic                       xpt_valid,               // packet request seen
  output logic [`HBH_XPT_W-1:0]      xpt_code                 // packet request code
);
  hbh_sync_if sy ();  // filtered pins

  // every asynchronous pin goes through the three-stage filter
  hbh_pin_sync u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pins    ({level_irq_n, user_timing_strap, external_packet_request,
               edge_irq_third_unhalt, edge_irq_second, edge_irq_first,
               host_bus_request_n}),
    .so      (sy.src)
  );

  // priority encoder, shared by cycle code and interrupt pick
  function automatic logic [1:0] hbh_top_idx(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : hbh_top_idx

  // state
  hbh_bus_t                bus_q, bus_d;       // handover state
  logic                    oclk_q, oclk_d;     // output clock divider
  logic                    ack_n_q, ack_n_d;   // grant acknowledge
  logic                    drv_q, drv_d;       // bus drive enable
  logic [`HBH_PRI_W-1:0]   pri_q, pri_d;       // priority code
  logic                    rst_seen_q;         // first cycle after release
  logic                    run_q, run_d;       // processor running
  logic                    endn_q, endn_d;     // byte order
  logic [2:0]              eprev_q, eprev_d;   // previous edge irq levels
  logic [2:0]              epend_q, epend_d;   // pending edge flags
  logic [`HBH_VEC_W-1:0]   vec_q, vec_d;       // presented irq
  logic                    xv_q, xv_d;         // packet request valid
  logic [`HBH_XPT_W-1:0]   xc_q, xc_d;         // packet code
  logic [1:0]              flt_q, flt_d;       // float settle count
  logic [2:0]              erise;              // rising edges this cycle
  logic                    oedge;              // output clock rising next

  // handover: float first, then acknowledge; release acknowledge then drive
  always_comb begin
    oclk_d  = ~oclk_q;                        // RULE9
    oedge   = ~oclk_q;
    bus_d   = bus_q;
    ack_n_d = ack_n_q;
    drv_d   = drv_q;
    flt_d   = flt_q;
    pri_d   = pri_q;
    if (oedge) begin                          // RULE10
      pri_d = hbh_top_idx(cycle_req);         // RULE7
    end
    unique case (bus_q)
      HBH_OWN: begin
        if (!sy.req_n) begin                  // RULE3
          drv_d = 1'b0;                       // RULE1
          flt_d = `HBH_FLT_SETTLE;
          bus_d = HBH_FLOAT;
        end
      end
      HBH_FLOAT: begin
        if (flt_q != 2'h0) begin
          flt_d = flt_q - 2'h1;
        end else if (oedge) begin
          ack_n_d = 1'b0;                     // RULE1
          bus_d   = HBH_GRANTED;
        end
      end
      HBH_GRANTED: begin
        if (sy.req_n) begin
          ack_n_d = 1'b1;                     // RULE2
          bus_d   = HBH_RETURN;
        end
      end
      HBH_RETURN: begin
        drv_d = 1'b1;                         // RULE2
        bus_d = HBH_OWN;
      end
    endcase
  end

  // run state, strap, interrupts and packet requests
  always_comb begin
    run_d   = run_q;
    endn_d  = endn_q;
    eprev_d = sy.eirq;
    erise   = sy.eirq & ~eprev_q;             // RULE11
    epend_d = epend_q;
    xv_d    = xv_q;
    xc_d    = xc_q;
    if (!rst_seen_q) begin
      run_d  = ~sy.req_n;                     // RULE5 RULE6
      endn_d = sy.strap;                      // RULE17
    end
    if (irq_ack) begin
      // encoder index 2 names flag 0, so shift down from the top bit
      epend_d = epend_q & ~(3'h4 >> hbh_top_idx({1'b0, epend_q[0], epend_q[1], epend_q[2]}));
    end
    if (rst_seen_q && !run_q && erise[2]) begin
      run_d    = 1'b1;                        // RULE13
      epend_d  = epend_d | {1'b0, erise[1:0]};
    end else begin
      epend_d  = epend_d | erise;             // set wins over clear
    end
    // first has top priority, level irq last
    if (epend_d[0]) begin                     // RULE12
      vec_d = `HBH_IRQ_FIRST;
    end else if (epend_d[1]) begin
      vec_d = `HBH_IRQ_SECOND;
    end else if (epend_d[2]) begin
      vec_d = `HBH_IRQ_THIRD;
    end else if (!sy.lirq_n) begin            // RULE14 RULE15
      vec_d = `HBH_IRQ_LEVEL;
    end else begin
      vec_d = `HBH_IRQ_NONE;
    end
    if (oedge) begin                          // RULE18
      xv_d = sy.xpt != 3'h0;
      xc_d = sy.xpt;
    end
  end

  // registers; reset gives idle outputs and a floated bus
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin                         // RULE16
      bus_q      <= HBH_RETURN;
      oclk_q     <= 1'b0;
      ack_n_q    <= 1'b1;
      drv_q      <= 1'b0;
      flt_q      <= 2'h0;
      pri_q      <= 2'h0;
      rst_seen_q <= 1'b0;
      run_q      <= 1'b0;
      endn_q     <= 1'b0;
      eprev_q    <= 3'h0;
      epend_q    <= 3'h0;
      vec_q      <= `HBH_IRQ_NONE;
      xv_q       <= 1'b0;
      xc_q       <= 3'h0;
    end else begin
      bus_q      <= bus_d;
      oclk_q     <= oclk_d;
      ack_n_q    <= ack_n_d;
      drv_q      <= drv_d;
      flt_q      <= flt_d;
      pri_q      <= pri_d;
      rst_seen_q <= 1'b1;
      run_q      <= run_d;
      endn_q     <= endn_d;
      eprev_q    <= eprev_d;
      epend_q    <= epend_d;
      vec_q      <= vec_d;
      xv_q       <= xv_d;
      xc_q       <= xc_d;
    end
  end

  assign local_output_clock     = oclk_q;
  assign host_grant_ack_n       = ack_n_q;
  assign bus_drive_en           = drv_q;
  assign cycle_start_en         = drv_q;    // RULE19
  assign pending_cycle_priority = pri_q;
  assign master_run             = run_q;
  assign big_endian             = endn_q;
  assign irq_vector             = vec_q;
  assign xpt_valid              = xv_q;
  assign xpt_code               = xc_q;

  // acknowledge low only once the bus is floated
  AST_ACK_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(ack_n_q) |-> !drv_q && $past(!drv_q, 2)) else $error("ack before float"); // RULE1
  // ack high precedes drive by one cycle
  AST_RET_ORDER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(drv_q) |-> ack_n_q && $past(ack_n_q) && $past(bus_q) == HBH_RETURN)
    else $error("drive before ack"); // RULE2
  sequence s_req_low; !sy.req_n && bus_q == HBH_OWN; endsequence
  AST_REQ_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_req_low |=> !drv_q ##[1:4] !ack_n_q) else $error("no grant"); // RULE4
  AST_NO_CYCLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ack_n_q |-> !cycle_start_en && !bus_drive_en) else $error("cycle while granted"); // RULE19
  AST_PRI_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$stable(pri_q) |-> $rose(oclk_q)) else $error("priority off clock"); // RULE10
  AST_RUN_STRAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rst_seen_q |=> run_q == !$past(sy.req_n) && endn_q == $past(sy.strap))
    else $error("strap not caught"); // RULE5
  AST_UNHALT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_seen_q && !run_q && erise[2] |=> run_q && !epend_q[2]) else $error("unhalt"); // RULE13
  AST_EDGE_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run_q && erise[0] |=> epend_q[0] && vec_q == `HBH_IRQ_FIRST) else $error("edge lost"); // RULE12
  AST_LEVEL_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    vec_q == `HBH_IRQ_LEVEL |-> $past(epend_d) == 3'h0) else $error("level over edge"); // RULE14
endmodule : hbh_top
`default_nettype wire

/* test_host_bus_handover_reset_control.sv */
// Purpose: self-checking bench for the host bus handover block
// Assumes: bench inputs change on the falling edge of sys_clk
// Notes:   cycle_req and irq_ack stand in for the processor core
`timescale 1ns/100ps
`default_nettype none
`include "hbh_map.svh"
module test_host_bus_handover_reset_control;
  logic       sys_clk;      // 8 ns clock
  logic       rst_n;        // sync reset, low
  logic       want;         // host model wants bus
  logic       req_n;        // request pin from host
  logic       ei1;          // first edge irq
  logic       ei2;          // second edge irq
  logic       ei3;          // third edge irq, unhalt
  logic       lirq_n;       // level irq, low
  logic       strap;        // byte-order strap
  logic [2:0] xreq;         // packet request code
  logic [3:0] creq;         // pending cycle requests
  logic       irq_ack;      // core took the vector
  logic       oclk;         // output clock
  logic       ack_n;        // grant acknowledge
  logic       bus_drive_en; // bus driven
  logic       cyc_en;       // cycles may start
  logic [1:0] pri;          // pending cycle code
  logic       master_run;   // core running
  logic       big_endian;   // byte order
  logic [2:0] irq_vector;   // top pending irq
  logic       xpt_valid;    // packet request seen
  logic [2:0] xpt_code;     // packet code
  int         err_count;    // mismatches
  int         checks;       // comparisons
  int         cyc;          // timeout counter
  hbh_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .host_bus_request_n(req_n),
    .edge_irq_first(ei1), .edge_irq_second(ei2), .edge_irq_third_unhalt(ei3),
    .level_irq_n(lirq_n), .user_timing_strap(strap), .external_packet_request(xreq),
    .cycle_req(creq), .irq_ack(irq_ack), .local_output_clock(oclk),
    .host_grant_ack_n(ack_n), .bus_drive_en(bus_drive_en), .cycle_start_en(cyc_en),
    .pending_cycle_priority(pri), .master_run(master_run), .big_endian(big_endian),
    .irq_vector(irq_vector), .xpt_valid(xpt_valid), .xpt_code(xpt_code));
  hbh_host_model host_u (.sys_clk(sys_clk), .want(want), .pri(pri),
    .host_bus_request_n(req_n));
  // free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // hang guard, well above the fewer than two hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("counts: checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  // bounded wait on the acknowledge level
  task automatic wait_ack(input logic v);
    int i;
    i = 0;
    while (ack_n !== v && i < 20) begin
      tick(1);
      i++;
    end
    chk("ack_wait", v, ack_n);
  endtask : wait_ack
  // pins settle for five cycles before release so the filter sees them
  task automatic do_reset(input logic w, input logic s);
    tick(1);
    rst_n = 1'b0;
    want = w;
    strap = s;
    tick(5);
    chk("ack_rst", 1, ack_n);
    chk("drv_rst", 0, bus_drive_en);
    chk("vec_rst", `HBH_IRQ_NONE, irq_vector);
    chk("run_rst", 0, master_run);
    rst_n = 1'b1;
    tick(4);
  endtask : do_reset
  task automatic ack_pulse;
    irq_ack = 1'b1;
    tick(1);
    irq_ack = 1'b0;
    tick(4);
  endtask : ack_pulse
  task automatic test_halt_boot;
    do_reset(1'b0, 1'b0);
    chk("run_halted", 0, master_run);
    chk("endian_lo", 0, big_endian);
    chk("drv_own", 1, bus_drive_en);
    ei3 = 1'b1;
    tick(8);
    chk("run_unhalt", 1, master_run);
    chk("vec_noflag", `HBH_IRQ_NONE, irq_vector);
    ei3 = 1'b0;
    tick(6);
    $display("test_halt_boot done");
  endtask : test_halt_boot
  task automatic test_handover;
    want = 1'b1;
    tick(2);
    chk("ack_sync", 1, ack_n);
    wait_ack(1'b0);
    chk("drv_float", 0, bus_drive_en);
    chk("cyc_block", 0, cyc_en);
    tick(5);
    chk("drv_hold", 0, bus_drive_en);
    want = 1'b0;
    wait_ack(1'b1);
    chk("drv_after", 0, bus_drive_en);
    tick(2);
    chk("drv_back", 1, bus_drive_en);
    chk("cyc_back", 1, cyc_en);
    $display("test_handover done");
  endtask : test_handover
  // single request per code, and a stack of requests for codes 1 to 3
  task automatic test_priority;
    for (int i = 0; i < 4; i++) begin
      creq = 4'(1 << i);
      tick(4);
      chk("pri_one", 3'(i), {1'b0, pri});
      creq = 4'hF >> (3 - i);
      tick(4);
      chk("pri_many", 3'(i), {1'b0, pri});
    end
    creq = 4'h0;
    $display("test_priority done");
  endtask : test_priority
  task automatic test_irq;
    lirq_n = 1'b0;
    tick(6);
    chk("vec_level", `HBH_IRQ_LEVEL, irq_vector);
    ei3 = 1'b1;
    tick(6);
    chk("vec_third", `HBH_IRQ_THIRD, irq_vector);
    ei2 = 1'b1;
    tick(6);
    chk("vec_second", `HBH_IRQ_SECOND, irq_vector);
    ei1 = 1'b1;
    tick(6);
    chk("vec_first", `HBH_IRQ_FIRST, irq_vector);
    ack_pulse();
    chk("vec_ack1", `HBH_IRQ_SECOND, irq_vector);
    ack_pulse();
    chk("vec_ack2", `HBH_IRQ_THIRD, irq_vector);
    ack_pulse();
    chk("vec_ack3", `HBH_IRQ_LEVEL, irq_vector);
    lirq_n = 1'b1;
    tick(6);
    chk("vec_clear", `HBH_IRQ_NONE, irq_vector);
    ei1 = 1'b0;
    ei2 = 1'b0;
    ei3 = 1'b0;
    $display("test_irq done");
  endtask : test_irq
  task automatic test_xpt_clock;
    logic c;
    xreq = 3'h5;
    tick(6);
    chk("xpt_valid", 1, xpt_valid);
    chk("xpt_code5", 3'h5, xpt_code);
    xreq = 3'h2;
    tick(6);
    chk("xpt_code2", 3'h2, xpt_code);
    xreq = 3'h0;
    tick(6);
    chk("xpt_idle", 0, xpt_valid);
    c = oclk;
    tick(1);
    chk("oclk_step", {2'b00, ~c}, oclk);
    $display("test_xpt_clock done");
  endtask : test_xpt_clock
  task automatic test_run_boot;
    do_reset(1'b1, 1'b1);
    chk("run_now", 1, master_run);
    chk("endian_hi", 1, big_endian);
    wait_ack(1'b0);
    want = 1'b0;
    wait_ack(1'b1);
    $display("test_run_boot done");
  endtask : test_run_boot
  // every input has a value at time zero
  initial begin
    cyc = 0;
    err_count = 0;
    checks = 0;
    rst_n = 1'b0;
    want = 1'b0;
    {ei1, ei2, ei3} = 3'h0;
    lirq_n = 1'b1;
    strap = 1'b0;
    xreq = 3'h0;
    creq = 4'h0;
    irq_ack = 1'b0;
    test_halt_boot();
    test_handover();
    test_priority();
    test_irq();
    test_xpt_clock();
    test_run_boot();
    conclude();
  end
endmodule : test_host_bus_handover_reset_control
`default_nettype wire
